// ===== lfh_regs.svh
`ifndef LFH_REGS_SVH
`define LFH_REGS_SVH

// Register byte offsets
`define LFH_OFS_CFG        8'h00
`define LFH_OFS_LOWER_LO   8'h04
`define LFH_OFS_LOWER_HI   8'h08
`define LFH_OFS_UPPER_LO   8'h0C
`define LFH_OFS_UPPER_HI   8'h10
`define LFH_OFS_MODE       8'h14
`define LFH_OFS_FIRST_LO   8'h18
`define LFH_OFS_FIRST_HI   8'h1C
`define LFH_OFS_NEXT_LO    8'h20
`define LFH_OFS_NEXT_HI    8'h24
`define LFH_OFS_ERR        8'h28
`define LFH_OFS_HOPS       8'h2C
`define LFH_OFS_CLEAN_CNT  8'h30
`define LFH_OFS_CLEAN_LO   8'h34
`define LFH_OFS_CLEAN_HI   8'h38
`define LFH_OFS_OOB_CNT    8'h3C
`define LFH_OFS_OOB_LO     8'h40
`define LFH_OFS_OOB_HI     8'h44
`define LFH_OFS_BAD_CNT    8'h48
`define LFH_OFS_BAD_LO     8'h4C
`define LFH_OFS_BAD_HI     8'h50
`define LFH_OFS_DIV_CNT    8'h54
`define LFH_OFS_DIV_LO     8'h58
`define LFH_OFS_DIV_HI     8'h5C
`define LFH_OFS_LOCK_CNT   8'h60
`define LFH_OFS_LOCK_LO    8'h64
`define LFH_OFS_LOCK_HI    8'h68

// Mode register fields
`define LFH_MODE_ENABLE    0
`define LFH_MODE_MCS       1
`define LFH_MODE_EXIT_FULL 2
`define LFH_MODE_CMD_TRIG  3
`define LFH_MODE_BUSY      4
`define LFH_MODE_NEXT_VLD  5
`define LFH_MODE_WIDE_BW   6
`define LFH_MODE_TRACKING  7

// Error word bits
`define LFH_ERR_OOB        16'h0001
`define LFH_ERR_BAD        16'h0002
`define LFH_ERR_DIV        16'h0004
`define LFH_ERR_LOCK       16'h0008

// Reset values and counter saturation limit
`define LFH_NO_PIN         5'h1F
`define LFH_RST_LOWER      64'h0000_0000_0000_0000
`define LFH_RST_UPPER      64'hFFFF_FFFF_FFFF_FFFF
`define LFH_CNT_MAX        32'hFFFF_FFFF

`endif

// ===== lfh_pkg.sv
`default_nettype none
package lfh_pkg;

    typedef enum logic [1:0] {
        LFH_IDLE = 2'b00,
        LFH_TUNE = 2'b01,
        LFH_CAL = 2'b10
    } lfh_fsm_t;

    typedef struct packed {
        logic [15:0] pin_s1;
        logic [15:0] pin_s2;
        logic pin_prev;
        logic [4:0] trig_pin;
        logic [63:0] lower;
        logic [63:0] upper;
        logic enable;
        logic mcs;
        logic exit_full;
        logic cmd_trig;
        logic [63:0] first_freq;
        logic [63:0] next_freq;
        logic next_valid;
        logic [63:0] tune_freq;
        logic entry_pending;
        logic [15:0] entry_err;
        logic [15:0] active_err;
        logic [31:0] hops;
        logic [31:0] clean_cnt;
        logic [31:0] oob_cnt;
        logic [31:0] bad_cnt;
        logic [31:0] div_cnt;
        logic [31:0] lock_cnt;
        logic [63:0] last_clean;
        logic [63:0] last_oob;
        logic [63:0] last_bad;
        logic [63:0] div_freq;
        logic [63:0] lock_freq;
        lfh_fsm_t fsm;
        logic tune_start;
        logic recal_start;
        logic wide_bw;
        logic tracking;
        logic busy;
        logic [31:0] rdata;
    } lfh_state_t;

endpackage
`default_nettype wire

// ===== lfh_hop_control.sv
//////////////////////////////////////////////////////////////////////////////
// Contract
// - Trigger source is pin or command, latched only when hopping is enabled.
// - Command-triggered hop retunes to the carried frequency without any pin.
// - Loop bandwidth goes wide for the whole time hopping is active.
// - Full exit narrows bandwidth, recalibrates both synthesizers, resumes tracking.
// - Quick exit keeps the wide bandwidth and skips recalibration.
// - Exit style is ignored on enable and applied only on disable.
// - Enable hops first to the first-hop frequency; disable ignores that value.
// - Disable ends hopping with chosen exit style, other fields ignored.
// - Pin assignment and bounds form config, writable only while radio off.
// - Pin assignment and frequency bounds read back.
// - Enable state, multichip sync and exit style read back.
// - Two 16-bit error words: entry error and active hop error.
// - 32-bit count of frequency changes since hopping was entered.
// - Count clean hops and keep last clean 64-bit frequency.
// - Count out-of-bounds requests and keep last such frequency.
// - Count invalid requests and keep last invalid frequency.
// - Count divider computation failures and keep their frequency.
// - Count lock failures and keep last lock-failed frequency.
// - Pin mode: preload next frequency, rising pin edge retunes to it.
// - Pin assignment picks one of sixteen pins, or a code meaning no pin is assigned.
//////////////////////////////////////////////////////////////////////////////
`include "lfh_regs.svh"
`default_nettype none

module lfh_hop_control
    import lfh_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [31:0] reg_rdata_o,
    input wire logic radio_on_i,
    input wire logic [15:0] trigger_pins_i,
    output logic [63:0] tune_freq_o,
    output logic tune_start_o,
    input wire logic tune_done_i,
    input wire logic tune_div_fail_i,
    input wire logic tune_lock_fail_i,
    output logic wide_bandwidth_o,
    output logic recal_start_o,
    input wire logic recal_done_i,
    output logic tracking_en_o,
    output logic multichip_sync_on_hop_o,
    output logic hop_mode_enable_o,
    output logic hop_busy_o
);

    //////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [31:0] sat_inc(input logic [31:0] v);
        sat_inc = (v == `LFH_CNT_MAX) ? v : v + 32'h0000_0001;
    endfunction

    lfh_state_t q;
    lfh_state_t d;

    logic pin_now;
    logic pin_rise;
    logic hop_go;
    logic [63:0] hop_f;
    logic [15:0] go_err;
    logic [15:0] done_err;

    //////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        d = q;
        d.tune_start = 1'b0;
        d.recal_start = 1'b0;
        d.rdata = 32'h0000_0000;
        hop_go = 1'b0;
        hop_f = q.next_freq;
        go_err = 16'h0000;
        done_err = 16'h0000;

        // Pins come from outside; the first stage feeds only the second
        d.pin_s1 = trigger_pins_i;
        d.pin_s2 = q.pin_s1;
        // Top bit set means no pin is assigned
        pin_now = ~q.trig_pin[4] & q.pin_s2[q.trig_pin[3:0]];
        pin_rise = pin_now & ~q.pin_prev;
        d.pin_prev = pin_now;

        if (reg_we_i) begin
            unique case (reg_addr_i)
                // Config is frozen while the radio runs, so a hop never sees
                // its bounds move underneath it
                `LFH_OFS_CFG: begin
                    if (!radio_on_i) begin
                        d.trig_pin = reg_wdata_i[4:0];
                    end
                end
                `LFH_OFS_LOWER_LO: begin
                    if (!radio_on_i) begin
                        d.lower[31:0] = reg_wdata_i;
                    end
                end
                `LFH_OFS_LOWER_HI: begin
                    if (!radio_on_i) begin
                        d.lower[63:32] = reg_wdata_i;
                    end
                end
                `LFH_OFS_UPPER_LO: begin
                    if (!radio_on_i) begin
                        d.upper[31:0] = reg_wdata_i;
                    end
                end
                `LFH_OFS_UPPER_HI: begin
                    if (!radio_on_i) begin
                        d.upper[63:32] = reg_wdata_i;
                    end
                end
                `LFH_OFS_FIRST_LO: begin
                    d.first_freq[31:0] = reg_wdata_i;
                end
                `LFH_OFS_FIRST_HI: begin
                    d.first_freq[63:32] = reg_wdata_i;
                end
                `LFH_OFS_NEXT_LO: begin
                    d.next_freq[31:0] = reg_wdata_i;
                end
                `LFH_OFS_NEXT_HI: begin
                    // Writing the high half is the hop command
                    d.next_freq[63:32] = reg_wdata_i;
                    d.next_valid = 1'b1;
                    if (q.fsm == LFH_IDLE && q.enable && q.cmd_trig) begin
                        hop_go = 1'b1;
                        hop_f = {reg_wdata_i, q.next_freq[31:0]};
                        d.next_valid = 1'b0;
                    end
                end
                `LFH_OFS_MODE: begin
                    // Mode changes are dropped unless the sequencer is idle, and win over a
                    // hop arriving in the same cycle
                    if (q.fsm == LFH_IDLE) begin
                        if (reg_wdata_i[`LFH_MODE_ENABLE]) begin
                            d.enable = 1'b1;
                            d.mcs = reg_wdata_i[`LFH_MODE_MCS];
                            d.cmd_trig = reg_wdata_i[`LFH_MODE_CMD_TRIG];
                            d.wide_bw = 1'b1;
                            d.tracking = 1'b0;
                            d.entry_pending = 1'b1;
                            d.entry_err = 16'h0000;
                            d.active_err = 16'h0000;
                            d.hops = 32'h0000_0000;
                            d.clean_cnt = 32'h0000_0000;
                            d.oob_cnt = 32'h0000_0000;
                            d.bad_cnt = 32'h0000_0000;
                            d.div_cnt = 32'h0000_0000;
                            d.lock_cnt = 32'h0000_0000;
                            d.next_valid = 1'b0;
                            hop_go = 1'b1;
                            hop_f = q.first_freq;
                        end else if (q.enable) begin
                            d.enable = 1'b0;
                            d.exit_full = reg_wdata_i[`LFH_MODE_EXIT_FULL];
                            hop_go = 1'b0;
                            if (reg_wdata_i[`LFH_MODE_EXIT_FULL]) begin
                                d.wide_bw = 1'b0;
                                d.recal_start = 1'b1;
                                d.fsm = LFH_CAL;
                            end
                            // Quick exit leaves the wide loop in place
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        // Pin-triggered hop to the preloaded frequency
        if (!reg_we_i && q.fsm == LFH_IDLE && q.enable && !q.cmd_trig &&
            pin_rise && q.next_valid) begin
            hop_go = 1'b1;
            hop_f = q.next_freq;
            d.next_valid = 1'b0;
        end

        // Requests are screened before the synthesizer moves
        if (hop_go) begin
            if (hop_f == 64'h0000_0000_0000_0000) begin
                go_err = `LFH_ERR_BAD;
                d.bad_cnt = sat_inc(d.bad_cnt);
                d.last_bad = hop_f;
            end else if (hop_f < q.lower || hop_f > q.upper) begin
                go_err = `LFH_ERR_OOB;
                d.oob_cnt = sat_inc(d.oob_cnt);
                d.last_oob = hop_f;
            end else begin
                d.tune_freq = hop_f;
                d.tune_start = 1'b1;
                d.fsm = LFH_TUNE;
            end
            if (go_err != 16'h0000) begin
                // Rejected: the oscillator stays where it was
                d.active_err = go_err;
                if (d.entry_pending) begin
                    d.entry_err = go_err;
                    d.entry_pending = 1'b0;
                end
            end
        end

        unique case (q.fsm)
            LFH_IDLE: begin
            end
            LFH_TUNE: begin
                if (tune_done_i) begin
                    if (tune_div_fail_i) begin
                        done_err = `LFH_ERR_DIV;
                        d.div_cnt = sat_inc(q.div_cnt);
                        d.div_freq = q.tune_freq;
                    end else begin
                        d.hops = sat_inc(q.hops);
                        if (tune_lock_fail_i) begin
                            done_err = `LFH_ERR_LOCK;
                            d.lock_cnt = sat_inc(q.lock_cnt);
                            d.lock_freq = q.tune_freq;
                        end else begin
                            d.clean_cnt = sat_inc(q.clean_cnt);
                            d.last_clean = q.tune_freq;
                        end
                    end
                    d.active_err = done_err;
                    if (q.entry_pending) begin
                        d.entry_err = done_err;
                        d.entry_pending = 1'b0;
                    end
                    d.fsm = LFH_IDLE;
                end
            end
            LFH_CAL: begin
                if (recal_done_i) begin
                    d.tracking = 1'b1;
                    d.fsm = LFH_IDLE;
                end
            end
            default: begin
                d.fsm = LFH_IDLE;
            end
        endcase

        d.busy = d.fsm != LFH_IDLE;
        // Read data stands for one cycle only; 64-bit values read in halves
        if (reg_re_i) begin
            unique case (reg_addr_i)
                `LFH_OFS_CFG: d.rdata = {27'h0000000, q.trig_pin};
                `LFH_OFS_LOWER_LO: d.rdata = q.lower[31:0];
                `LFH_OFS_LOWER_HI: d.rdata = q.lower[63:32];
                `LFH_OFS_UPPER_LO: d.rdata = q.upper[31:0];
                `LFH_OFS_UPPER_HI: d.rdata = q.upper[63:32];
                `LFH_OFS_MODE: begin
                    d.rdata[`LFH_MODE_ENABLE] = q.enable;
                    d.rdata[`LFH_MODE_MCS] = q.mcs;
                    d.rdata[`LFH_MODE_EXIT_FULL] = q.exit_full;
                    d.rdata[`LFH_MODE_CMD_TRIG] = q.cmd_trig;
                    d.rdata[`LFH_MODE_BUSY] = q.busy;
                    d.rdata[`LFH_MODE_NEXT_VLD] = q.next_valid;
                    d.rdata[`LFH_MODE_WIDE_BW] = q.wide_bw;
                    d.rdata[`LFH_MODE_TRACKING] = q.tracking;
                end
                `LFH_OFS_FIRST_LO: d.rdata = q.first_freq[31:0];
                `LFH_OFS_FIRST_HI: d.rdata = q.first_freq[63:32];
                `LFH_OFS_NEXT_LO: d.rdata = q.next_freq[31:0];
                `LFH_OFS_NEXT_HI: d.rdata = q.next_freq[63:32];
                `LFH_OFS_ERR: d.rdata = {q.active_err, q.entry_err};
                `LFH_OFS_HOPS: d.rdata = q.hops;
                `LFH_OFS_CLEAN_CNT: d.rdata = q.clean_cnt;
                `LFH_OFS_CLEAN_LO: d.rdata = q.last_clean[31:0];
                `LFH_OFS_CLEAN_HI: d.rdata = q.last_clean[63:32];
                `LFH_OFS_OOB_CNT: d.rdata = q.oob_cnt;
                `LFH_OFS_OOB_LO: d.rdata = q.last_oob[31:0];
                `LFH_OFS_OOB_HI: d.rdata = q.last_oob[63:32];
                `LFH_OFS_BAD_CNT: d.rdata = q.bad_cnt;
                `LFH_OFS_BAD_LO: d.rdata = q.last_bad[31:0];
                `LFH_OFS_BAD_HI: d.rdata = q.last_bad[63:32];
                `LFH_OFS_DIV_CNT: d.rdata = q.div_cnt;
                `LFH_OFS_DIV_LO: d.rdata = q.div_freq[31:0];
                `LFH_OFS_DIV_HI: d.rdata = q.div_freq[63:32];
                `LFH_OFS_LOCK_CNT: d.rdata = q.lock_cnt;
                `LFH_OFS_LOCK_LO: d.rdata = q.lock_freq[31:0];
                `LFH_OFS_LOCK_HI: d.rdata = q.lock_freq[63:32];
                default: d.rdata = 32'h0000_0000;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.trig_pin <= `LFH_NO_PIN;
            q.lower <= `LFH_RST_LOWER;
            q.upper <= `LFH_RST_UPPER;
            q.cmd_trig <= 1'b1;
            q.fsm <= LFH_IDLE;
        end else begin
            q <= d;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Outputs, all from flops

    assign reg_rdata_o = q.rdata;
    assign tune_freq_o = q.tune_freq;
    assign tune_start_o = q.tune_start;
    assign wide_bandwidth_o = q.wide_bw;
    assign recal_start_o = q.recal_start;
    assign tracking_en_o = q.tracking;
    assign multichip_sync_on_hop_o = q.mcs;
    assign hop_mode_enable_o = q.enable;
    assign hop_busy_o = q.busy;

endmodule // lfh_hop_control
`default_nettype wire

// ===== lfh_hop_control_sva.sv
`include "lfh_regs.svh"
`default_nettype none
module lfh_hop_control_sva
    import lfh_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic radio_on_i,
    input wire logic [15:0] trigger_pins_i,
    input wire logic [63:0] tune_freq_o,
    input wire logic tune_start_o,
    input wire logic tune_done_i,
    input wire logic tune_div_fail_i,
    input wire logic tune_lock_fail_i,
    input wire logic wide_bandwidth_o,
    input wire logic recal_start_o,
    input wire logic recal_done_i,
    input wire logic tracking_en_o,
    input wire logic multichip_sync_on_hop_o,
    input wire logic hop_mode_enable_o,
    input wire logic hop_busy_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // A mode write while busy is refused, so only idle ones count
    wire mode_wr = reg_we_i && reg_addr_i == `LFH_OFS_MODE && !hop_busy_o;
    sequence s_tune; tune_start_o ##[1:40] tune_done_i; endsequence
    sequence s_recal; recal_start_o ##[1:40] recal_done_i; endsequence
    property p_pulse; tune_start_o |=> !tune_start_o; endproperty
    property p_rdata; reg_rdata_o != 32'h0 |-> $past(reg_re_i); endproperty
    property p_wide; hop_mode_enable_o |-> wide_bandwidth_o; endproperty
    property p_full;
        $fell(hop_mode_enable_o) && !wide_bandwidth_o |-> recal_start_o && hop_busy_o;
    endproperty
    property p_quick;
        $fell(hop_mode_enable_o) && wide_bandwidth_o |-> !recal_start_o && !hop_busy_o;
    endproperty
    property p_tune; s_tune |=> !hop_busy_o; endproperty
    property p_recal; s_recal |=> tracking_en_o && !hop_busy_o; endproperty
    property p_freq; !tune_start_o |-> $stable(tune_freq_o); endproperty
    property p_enter;
        mode_wr && reg_wdata_i[0] |=> hop_mode_enable_o && !tracking_en_o && !recal_start_o
            && multichip_sync_on_hop_o == $past(reg_wdata_i[1]);
    endproperty
    property p_exit;
        mode_wr && !reg_wdata_i[0] && hop_mode_enable_o |=> !hop_mode_enable_o
            && wide_bandwidth_o == !$past(reg_wdata_i[2]) && $stable(multichip_sync_on_hop_o);
    endproperty
    a_pulse: assert property (p_pulse) else $error("tune start longer than one cycle");
    a_rdata: assert property (p_rdata) else $error("read data without a read");
    a_wide: assert property (p_wide) else $error("narrow bandwidth while hopping");
    a_full: assert property (p_full) else $error("full exit without recalibration");
    a_quick: assert property (p_quick) else $error("quick exit recalibrated");
    a_tune: assert property (p_tune) else $error("busy after tune done");
    a_recal: assert property (p_recal) else $error("tracking not resumed");
    a_freq: assert property (p_freq) else $error("frequency moved without tune");
    a_enter: assert property (p_enter) else $error("enable write misapplied");
    a_exit: assert property (p_exit) else $error("disable write misapplied");
endmodule // lfh_hop_control_sva
bind lfh_hop_control lfh_hop_control_sva chk_u (.clk_i(clk_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
    .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .radio_on_i(radio_on_i),
    .trigger_pins_i(trigger_pins_i), .tune_freq_o(tune_freq_o), .tune_start_o(tune_start_o),
    .tune_done_i(tune_done_i), .tune_div_fail_i(tune_div_fail_i),
    .tune_lock_fail_i(tune_lock_fail_i), .wide_bandwidth_o(wide_bandwidth_o),
    .recal_start_o(recal_start_o), .recal_done_i(recal_done_i),
    .tracking_en_o(tracking_en_o), .multichip_sync_on_hop_o(multichip_sync_on_hop_o),
    .hop_mode_enable_o(hop_mode_enable_o), .hop_busy_o(hop_busy_o));
`default_nettype wire

// ===== lfh_synth_model.sv
`default_nettype none
module lfh_synth_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tune_start_i,
    input wire logic recal_start_i,
    input wire logic [3:0] delay_i,
    input wire logic div_fail_i,
    input wire logic lock_fail_i,
    output logic done_o = 1'b0,
    output logic div_o,
    output logic lock_o,
    output logic recal_done_o = 1'b0
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [4:0] tune_cnt = 5'h00;
    logic [4:0] cal_cnt = 5'h00;
    logic noise = 1'b0;
    // Qualifiers carry junk outside the done pulse, so early sampling shows up
    assign div_o = done_o ? div_fail_i : noise;
    assign lock_o = done_o ? lock_fail_i : ~noise;
    always @(posedge clk_i) begin
        noise <= ~noise;
        done_o <= !rst_i && tune_cnt == 5'h01;
        recal_done_o <= !rst_i && cal_cnt == 5'h01;
        if (rst_i) begin
            tune_cnt <= 5'h00;
            cal_cnt <= 5'h00;
        end else begin
            if (tune_start_i) tune_cnt <= {1'b0, delay_i} + 5'h01;
            else if (tune_cnt != 5'h00) tune_cnt <= tune_cnt - 5'h01;
            if (recal_start_i) cal_cnt <= {1'b0, delay_i} + 5'h01;
            else if (cal_cnt != 5'h00) cal_cnt <= cal_cnt - 5'h01;
        end
    end
endmodule // lfh_synth_model
`default_nettype wire

// ===== lfh_hop_control_test.sv
`include "lfh_regs.svh"
`default_nettype none
module lfh_hop_control_test
    import lfh_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, rst = 1'b1, we = 1'b0, re = 1'b0, radio = 1'b0;
    logic mdiv = 1'b0, mlock = 1'b0;
    logic [3:0] dly = 4'h2;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [15:0] pins = 16'h0;
    logic [63:0] tfreq;
    logic tstart, tdone, dfail, lfail, wide, rstart, rdone, track, mcs, en, busy;
    int err_count = 0;
    int compares = 0;
    always #2.5 clk = ~clk;
    lfh_hop_control dut_u (.clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .radio_on_i(radio),
        .trigger_pins_i(pins), .tune_freq_o(tfreq), .tune_start_o(tstart),
        .tune_done_i(tdone), .tune_div_fail_i(dfail), .tune_lock_fail_i(lfail),
        .wide_bandwidth_o(wide), .recal_start_o(rstart), .recal_done_i(rdone),
        .tracking_en_o(track), .multichip_sync_on_hop_o(mcs), .hop_mode_enable_o(en),
        .hop_busy_o(busy));
    lfh_synth_model syn_u (.clk_i(clk), .rst_i(rst), .tune_start_i(tstart),
        .recal_start_i(rstart), .delay_i(dly), .div_fail_i(mdiv), .lock_fail_i(mlock),
        .done_o(tdone), .div_o(dfail), .lock_o(lfail), .recal_done_o(rdone));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        we <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        we <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
        @(posedge clk);
        re <= 1'b1;
        addr <= a;
        @(posedge clk);
        re <= 1'b0;
        #1;
        check(name, rdata, exp);
    endtask
    task automatic idle;
        for (int n = 0; n < 100 && busy !== 1'b0; n++) @(posedge clk);
        #1;
        check("busy", busy, 1'b0);
    endtask
    task automatic radio_set(input logic on);
        @(posedge clk);
        radio <= on;
    endtask
    task automatic hop(input logic [31:0] f, input logic go, input logic [31:0] exp_f);
        wr(`LFH_OFS_NEXT_LO, f);
        wr(`LFH_OFS_NEXT_HI, 32'h0);
        check("start", tstart, go);
        check("freq", tfreq, {32'h0, exp_f});
        if (go) idle();
        repeat (3) @(posedge clk);
    endtask
    task automatic pulse(input logic [15:0] m, input logic exp);
        logic seen;
        seen = 1'b0;
        @(posedge clk);
        pins <= m;
        repeat (8) begin
            @(posedge clk);
            #1;
            if (tstart === 1'b1) seen = 1'b1;
        end
        @(posedge clk);
        pins <= 16'h0;
        check("pin hop", seen, exp);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(`LFH_OFS_CFG, {27'h0, `LFH_NO_PIN}, "pin");
        rd(`LFH_OFS_UPPER_HI, 32'hFFFF_FFFF, "upper");
        rd(`LFH_OFS_MODE, 32'h0000_0008, "mode");
        rd(8'hFC, 32'h0, "unmapped");
        $display("test reset done");
    endtask
    task automatic t_config;
        wr(`LFH_OFS_CFG, 32'h0000_0003);
        wr(`LFH_OFS_UPPER_LO, 32'h0000_03E8);
        wr(`LFH_OFS_UPPER_HI, 32'h0);
        rd(`LFH_OFS_CFG, 32'h0000_0003, "pin");
        rd(`LFH_OFS_UPPER_LO, 32'h0000_03E8, "upper");
        radio_set(1'b1);
        wr(`LFH_OFS_CFG, 32'h0000_0005);
        wr(`LFH_OFS_LOWER_LO, 32'h0000_0007);
        rd(`LFH_OFS_CFG, 32'h0000_0003, "pin locked");
        rd(`LFH_OFS_LOWER_LO, 32'h0, "lower locked");
        $display("test config done");
    endtask
    task automatic t_enter;
        wr(`LFH_OFS_FIRST_LO, 32'h0000_00C8);
        wr(`LFH_OFS_FIRST_HI, 32'h0);
        wr(`LFH_OFS_MODE, 32'h0000_000B);
        check("start", tstart, 1'b1);
        check("freq", tfreq, 64'h0000_0000_0000_00C8);
        idle();
        rd(`LFH_OFS_MODE, 32'h0000_004B, "mode");
        rd(`LFH_OFS_HOPS, 32'h0000_0001, "hops");
        rd(`LFH_OFS_CLEAN_CNT, 32'h0000_0001, "clean");
        rd(`LFH_OFS_ERR, 32'h0, "errors");
        $display("test enter done");
    endtask
    task automatic t_hops;
        dly = 4'hA;
        hop(32'h0000_012C, 1'b1, 32'h0000_012C);
        dly <= 4'h1;
        hop(32'h0, 1'b0, 32'h0000_012C);
        hop(32'h0000_07D0, 1'b0, 32'h0000_012C);
        mdiv <= 1'b1;
        hop(32'h0000_0190, 1'b1, 32'h0000_0190);
        mdiv <= 1'b0;
        mlock <= 1'b1;
        hop(32'h0000_01F4, 1'b1, 32'h0000_01F4);
        mlock <= 1'b0;
        rd(`LFH_OFS_HOPS, 32'h0000_0003, "hops");
        rd(`LFH_OFS_CLEAN_CNT, 32'h0000_0002, "clean");
        rd(`LFH_OFS_CLEAN_LO, 32'h0000_012C, "last clean");
        rd(`LFH_OFS_OOB_CNT, 32'h0000_0001, "oob");
        rd(`LFH_OFS_OOB_LO, 32'h0000_07D0, "last oob");
        rd(`LFH_OFS_BAD_CNT, 32'h0000_0001, "bad");
        rd(`LFH_OFS_DIV_CNT, 32'h0000_0001, "div");
        rd(`LFH_OFS_DIV_LO, 32'h0000_0190, "div freq");
        rd(`LFH_OFS_LOCK_CNT, 32'h0000_0001, "lock");
        rd(`LFH_OFS_LOCK_LO, 32'h0000_01F4, "lock freq");
        $display("test hops done");
    endtask
    task automatic t_pin;
        wr(`LFH_OFS_MODE, 32'h0);
        check("enable", en, 1'b0);
        check("wide", wide, 1'b1);
        check("recal", rstart, 1'b0);
        wr(`LFH_OFS_MODE, 32'h0000_0001);
        idle();
        rd(`LFH_OFS_OOB_CNT, 32'h0, "oob cleared");
        hop(32'h0000_0258, 1'b0, 32'h0000_00C8);
        pulse(16'h0020, 1'b0);
        pulse(16'h0008, 1'b1);
        check("freq", tfreq, 64'h0000_0000_0000_0258);
        idle();
        $display("test pin done");
    endtask
    task automatic t_exit;
        wr(`LFH_OFS_MODE, 32'h0000_000D);
        check("recal", rstart, 1'b0);
        check("wide", wide, 1'b1);
        idle();
        wr(`LFH_OFS_MODE, 32'h0000_0006);
        check("enable", en, 1'b0);
        check("wide", wide, 1'b0);
        check("recal", rstart, 1'b1);
        check("sync", mcs, 1'b0);
        idle();
        check("tracking", track, 1'b1);
        rd(`LFH_OFS_MODE, 32'h8C, "mode");
        $display("test exit done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_config();
        t_enter();
        t_hops();
        t_pin();
        t_exit();
        report_and_stop();
    end
    // The whole sequence needs well under 2000 cycles
    initial begin
        #50000;
        err_count++;
        report_and_stop();
    end
endmodule // lfh_hop_control_test
`default_nettype wire
